// ===== hw/crd_top.sv
// clock controller: source requests, main clock switch and prescaler,
// asynchronous peripheral clock gates, clock output pin.
// assumes peripheral requests, sleep state and memory busy are
// synchronous levels; clocks are modelled as one-cycle enables.
//
// Local design decisions: the address map and strobed register access.
`default_nettype none

module crd_top #(
  parameter int STARTUP_CYCLES = crd_pkg::OSC_STARTUP_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic [crd_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [crd_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  output logic [crd_pkg::DATA_W-1:0] REG_RDATA,
  input wire crd_pkg::crd_sleep_type SLEEP_STATE,
  input wire crd_pkg::crd_periph_req_type PERIPH_REQ,
  input wire logic NVM_BUSY,
  output logic [crd_pkg::NUM_SRC-1:0] OSC_ENABLE,
  output crd_pkg::crd_gates_type CLOCK_GATES,
  output logic CLOCK_OUTPUT_PIN
);
  import crd_pkg::*;

  // ==========================================================
  // register state
  crd_src_type main_source_select_q;
  logic clock_output_enable_q;
  logic [CODE_W-1:0] prescale_code_q;
  logic [NUM_SRC-1:0] run_in_standby_q;
  logic [DATA_W-1:0] rdata_q;

  // ==========================================================
  // internal state and nets
  crd_src_type active_src_q;
  logic [SRC_W-1:0] rtc_src_q;
  logic [SRC_W-1:0] tcd_src_q;
  crd_gates_type gates_q;
  crd_gates_type gates_d;
  logic pin_q;
  logic [NUM_SRC-1:0] src_request;
  logic [NUM_SRC-1:0] src_ready;
  logic main_run;
  logic switching;
  logic power_down;
  logic rtc_req;
  logic watchdog_req;
  logic brownout_req;
  logic tcd_req;
  logic per_tick;
  logic wr_a;
  logic wr_b;
  logic wr_s;
  logic [DATA_W-1:0] rd_mux;

  // ==========================================================
  // register writes
  assign wr_a = REG_WRITE && (REG_ADDR == OFS_MAIN_CTRL_A);
  assign wr_b = REG_WRITE && (REG_ADDR == OFS_MAIN_CTRL_B);
  assign wr_s = REG_WRITE && (REG_ADDR == OFS_RUN_STDBY);

  // main source select and clock output enable
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      main_source_select_q <= SRC_FAST_INTERNAL;
      clock_output_enable_q <= 1'b0;
    end else if (CE && wr_a) begin
      main_source_select_q <=
        crd_src_type'(REG_WDATA[SEL_LSB +: SRC_W]);
      clock_output_enable_q <= REG_WDATA[OUT_EN_BIT];
    end
  end

  // prescaler code; codes past the twelfth are ignored, not stored,
  // so a stray write can never leave the divider without a setting
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      prescale_code_q <= CODE_DIV6;
    end else if (CE && wr_b &&
                 (REG_WDATA[CODE_LSB +: CODE_W] < CODE_COUNT)) begin
      prescale_code_q <= REG_WDATA[CODE_LSB +: CODE_W];
    end
  end

  // one run-in-standby bit per oscillator
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      run_in_standby_q <= RUN_STDBY_RESET;
    end else if (CE && wr_s) begin
      run_in_standby_q <= REG_WDATA[NUM_SRC-1:0];
    end
  end

  // ==========================================================
  // register reads: data stand one cycle after the strobe
  // status shows live values; nothing in it is cleared by a read
  always_comb begin
    rd_mux = RDATA_ZERO;
    unique case (REG_ADDR)
      OFS_MAIN_CTRL_A: begin
        rd_mux[SEL_LSB +: SRC_W] = main_source_select_q;
        rd_mux[OUT_EN_BIT] = clock_output_enable_q;
      end
      OFS_MAIN_CTRL_B: begin
        rd_mux[CODE_LSB +: CODE_W] = prescale_code_q;
      end
      OFS_RUN_STDBY: begin
        rd_mux[NUM_SRC-1:0] = run_in_standby_q;
      end
      OFS_STATUS: begin
        rd_mux[NUM_SRC-1:0] = src_ready;
        rd_mux[STAT_SWITCHING_BIT] = switching;
        rd_mux[STAT_MAIN_RUN_BIT] = gates_q.main_clock;
      end
      default: begin
        rd_mux = RDATA_ZERO; // unmapped reads as zero
      end
    endcase
  end

  // read data only in the cycle after the read strobe
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rdata_q <= RDATA_ZERO;
    end else if (CE) begin
      rdata_q <= REG_READ ? rd_mux : RDATA_ZERO;
    end
  end

  assign REG_RDATA = rdata_q;

  // ==========================================================
  // asynchronous clock source selects: taken only while the owner
  // is disabled, so a careless change never glitches a running clock
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rtc_src_q <= SRC_LOW_POWER_INTERNAL;
    end else if (CE && !PERIPH_REQ.rtc_enable) begin
      rtc_src_q <= PERIPH_REQ.rtc_source;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      tcd_src_q <= SRC_FAST_INTERNAL;
    end else if (CE && !PERIPH_REQ.control_timer_enable) begin
      tcd_src_q <= PERIPH_REQ.control_timer_source;
    end
  end

  // ==========================================================
  // peripheral clock requests
  assign rtc_req = PERIPH_REQ.rtc_enable;
  assign watchdog_req = PERIPH_REQ.watchdog_enable;
  assign brownout_req = PERIPH_REQ.brownout_enable &&
                        PERIPH_REQ.brownout_sampled;
  assign tcd_req = PERIPH_REQ.control_timer_enable;
  assign power_down = (SLEEP_STATE == SLEEP_POWER_DOWN);

  // main clock demand per sleep state
  // power-down holds the clock only for memory work still in flight
  always_comb begin
    main_run = 1'b0;
    unique case (SLEEP_STATE)
      SLEEP_ACTIVE, SLEEP_IDLE: begin
        main_run = 1'b1;
      end
      SLEEP_STANDBY: begin
        main_run = PERIPH_REQ.main_request ||
                   run_in_standby_q[active_src_q];
      end
      SLEEP_POWER_DOWN: begin
        main_run = NVM_BUSY;
      end
    endcase
  end

  // route each request to the source its consumer uses
  // a pending switch asks for the new source early, so it warms up
  always_comb begin
    for (int s = 0; s < NUM_SRC; s++) begin
      src_request[s] =
        (rtc_req && (rtc_src_q == SRC_W'(s))) ||
        (tcd_req && (tcd_src_q == SRC_W'(s))) ||
        (main_run && (active_src_q == SRC_W'(s))) ||
        (main_run && switching &&
         (main_source_select_q == SRC_W'(s))) ||
        (run_in_standby_q[s] && !power_down);
    end
    // watchdog and brownout always run off the low power source
    src_request[SRC_LOW_POWER_INTERNAL] =
      src_request[SRC_LOW_POWER_INTERNAL] ||
      watchdog_req || brownout_req;
  end

  // ==========================================================
  // oscillators: on when requested, off otherwise
  // one instance per source keeps the start-up logic in one place
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_osc
    crd_osc_request #(
      .STARTUP_CYCLES(STARTUP_CYCLES)
    ) u_osc (
      .clk(CLK),
      .rst_b(RST_B),
      .ce(CE),
      .request(src_request[g]),
      .osc_enable(OSC_ENABLE[g]),
      .ready(src_ready[g])
    );
  end

  // ==========================================================
  // main clock switch: hold the old source until the new one is up,
  // so a dead external source never stops the running clock
  // limitation: a source that never comes up leaves the switch
  // pending until a reset or a write that selects the running source again
  assign switching = (main_source_select_q != active_src_q);

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      active_src_q <= SRC_FAST_INTERNAL;
    end else if (CE && switching && src_ready[main_source_select_q]) begin
      active_src_q <= main_source_select_q;
    end
  end

  // ==========================================================
  // prescaler for cpu and peripheral clocks
  crd_prescaler #(
    .DIV_W(DIV_W)
  ) u_presc (
    .clk(CLK),
    .rst_b(RST_B),
    .ce(CE),
    .run(gates_d.main_clock),
    .divide(crd_divisor(prescale_code_q)),
    .tick(per_tick)
  );

  // ==========================================================
  // clock gates
  always_comb begin
    gates_d.main_clock = main_run && src_ready[active_src_q];
    gates_d.cpu_clock = per_tick;
    gates_d.peripheral_clock = per_tick;
    gates_d.rtc_clock = rtc_req && src_ready[rtc_src_q];
    gates_d.watchdog_clock = watchdog_req &&
      src_ready[SRC_LOW_POWER_INTERNAL];
    gates_d.brownout_clock = brownout_req &&
      src_ready[SRC_LOW_POWER_INTERNAL];
    gates_d.control_timer_clock = tcd_req &&
      src_ready[tcd_src_q];
  end

  // gates leave through flip-flops, one cycle after the decision
  // the extra cycle of latency buys glitch-free gate outputs
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      gates_q <= '0;
    end else if (CE) begin
      gates_q <= gates_d;
    end
  end

  assign CLOCK_GATES = gates_q;

  // ==========================================================
  // clock output pin: peripheral clock pulse, low when disabled
  // a one-cycle tick, not a square wave: outside logic must count
  // rising edges of the pin rather than measure its duty
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      pin_q <= 1'b0;
    end else if (CE) begin
      pin_q <= clock_output_enable_q && per_tick;
    end
  end

  assign CLOCK_OUTPUT_PIN = pin_q;

endmodule // crd_top

`default_nettype wire

// ===== hw/crd_pkg.sv
// package for the clock request and distribution block: register map,
// field layout, reset values, source and sleep encodings, carriers.
// assumes a single 10 MHz system clock and an 8-bit register port.
`default_nettype none

package crd_pkg;

  // ==========================================================
  // sizes and timing
  localparam int NUM_SRC = 4;
  localparam int SRC_W = 2;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int DIV_W = 7;
  localparam int CODE_W = 4;
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_STARTUP_NS = 2000;
  // least time, so round up to whole cycles
  localparam int OSC_STARTUP_CYCLES =
    (OSC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_MAIN_CTRL_A = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_MAIN_CTRL_B = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_RUN_STDBY = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h3;

  // ==========================================================
  // field positions and reset values
  localparam int SEL_LSB = 0;
  localparam int OUT_EN_BIT = 7;
  localparam int CODE_LSB = 0;
  localparam int STAT_SWITCHING_BIT = 4;
  localparam int STAT_MAIN_RUN_BIT = 5;
  localparam logic [CODE_W-1:0] CODE_DIV6 = 4'h7;
  localparam logic [CODE_W-1:0] CODE_COUNT = 4'hC;
  localparam logic [NUM_SRC-1:0] RUN_STDBY_RESET = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 8'h00;

  // ==========================================================
  // encodings
  typedef enum logic [SRC_W-1:0] {
    SRC_FAST_INTERNAL = 2'b00,
    SRC_LOW_POWER_INTERNAL = 2'b01,
    SRC_CRYSTAL = 2'b10,
    SRC_EXTERNAL = 2'b11
  } crd_src_type;

  typedef enum logic [1:0] {
    SLEEP_ACTIVE = 2'b00,
    SLEEP_IDLE = 2'b01,
    SLEEP_STANDBY = 2'b10,
    SLEEP_POWER_DOWN = 2'b11
  } crd_sleep_type;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic rtc_enable;
    logic [SRC_W-1:0] rtc_source;
    logic watchdog_enable;
    logic brownout_enable;
    logic brownout_sampled;
    logic control_timer_enable;
    logic [SRC_W-1:0] control_timer_source;
    logic main_request;
  } crd_periph_req_type;

  typedef struct packed {
    logic main_clock;
    logic cpu_clock;
    logic peripheral_clock;
    logic rtc_clock;
    logic watchdog_clock;
    logic brownout_clock;
    logic control_timer_clock;
  } crd_gates_type;

  // twelve prescaler settings, 1x to 64x
  function automatic logic [DIV_W-1:0] crd_divisor(
    input logic [CODE_W-1:0] code);
    unique case (code)
      4'h0: crd_divisor = 7'h01;
      4'h1: crd_divisor = 7'h02;
      4'h2: crd_divisor = 7'h04;
      4'h3: crd_divisor = 7'h08;
      4'h4: crd_divisor = 7'h10;
      4'h5: crd_divisor = 7'h20;
      4'h6: crd_divisor = 7'h40;
      4'h7: crd_divisor = 7'h06;
      4'h8: crd_divisor = 7'h0A;
      4'h9: crd_divisor = 7'h0C;
      4'hA: crd_divisor = 7'h18;
      4'hB: crd_divisor = 7'h30;
      default: crd_divisor = 7'h06;
    endcase
  endfunction

endpackage : crd_pkg

`default_nettype wire

// ===== hw/crd_osc_request.sv
// one oscillator's on/off control with start-up delay.
// assumes the request is a synchronous level in the system clock domain.
`default_nettype none

module crd_osc_request #(
  parameter int STARTUP_CYCLES = crd_pkg::OSC_STARTUP_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic request,
  output logic osc_enable,
  output logic ready
);
  import crd_pkg::*;

  localparam int CNT_W = $clog2(STARTUP_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STARTUP_CYCLES - 1);

  logic [CNT_W-1:0] cnt_q;
  logic on_q;
  logic ready_q;

  // ==========================================================
  // oscillator power follows the request, off when nobody asks
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      on_q <= 1'b0;
    end else if (ce) begin
      on_q <= request;
    end
  end

  // start-up count; a source kept warm stays ready, so no delay
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_q <= '0;
      ready_q <= 1'b0;
    end else if (ce) begin
      if (!request) begin
        cnt_q <= '0;
        ready_q <= 1'b0;
      end else if (on_q && !ready_q) begin
        if (cnt_q == CNT_LAST) begin
          ready_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  assign osc_enable = on_q;
  assign ready = ready_q;

endmodule // crd_osc_request

`default_nettype wire

// ===== hw/crd_prescaler.sv
// main clock prescaler: one tick every 'divide' main clock cycles.
// assumes divide is 1 or more; run marks cycles with main clock present.
`default_nettype none

module crd_prescaler #(
  parameter int DIV_W = crd_pkg::DIV_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic run,
  input wire logic [DIV_W-1:0] divide,
  output logic tick
);
  import crd_pkg::*;

  logic [DIV_W-1:0] cnt_q;
  logic tick_q;

  // ==========================================================
  // count main clock cycles; a shrunk divisor wraps at once
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        tick_q <= 1'b0;
      end else if (cnt_q >= divide - 1'b1) begin
        cnt_q <= '0;
        tick_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
        tick_q <= 1'b0;
      end
    end
  end

  assign tick = tick_q;

endmodule // crd_prescaler

`default_nettype wire

// ===== verification/crd_periph_model.sv
// peripheral side model: drives the clock request levels of the block.
// assumes one system clock; the bench states wanted levels in want.
`default_nettype none

module crd_periph_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire crd_pkg::crd_periph_req_type want,
  output crd_pkg::crd_periph_req_type req
);
  timeunit 1ns;
  timeprecision 1ns;
  import crd_pkg::*;

  // ==========================================================
  // request levels
  // a source moves only while its peripheral is off, and the enable
  // waits one cycle after a move so the controller latches it first
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      req <= '0;
    end else begin
      req <= want;
      if (req.rtc_enable) begin
        req.rtc_source <= req.rtc_source;
      end else begin
        req.rtc_enable <= want.rtc_enable &&
          want.rtc_source == req.rtc_source;
      end
      if (req.control_timer_enable) begin
        req.control_timer_source <= req.control_timer_source;
      end else begin
        req.control_timer_enable <= want.control_timer_enable &&
          want.control_timer_source == req.control_timer_source;
      end
    end
  end
endmodule // crd_periph_model

`default_nettype wire

// ===== verification/crd_chk.sv
// checker for the clock request block, bound to the top module.
// assumes CE drops only briefly, while nothing is in flight.
`default_nettype none

module crd_chk #(
  parameter int STARTUP_CYCLES = 20
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic REG_READ,
  input wire logic [crd_pkg::DATA_W-1:0] REG_RDATA,
  input wire crd_pkg::crd_sleep_type SLEEP_STATE,
  input wire crd_pkg::crd_periph_req_type PERIPH_REQ,
  input wire logic NVM_BUSY,
  input wire logic [crd_pkg::NUM_SRC-1:0] OSC_ENABLE,
  input wire crd_pkg::crd_gates_type CLOCK_GATES,
  input wire logic CLOCK_OUTPUT_PIN
);
  timeunit 1ns;
  timeprecision 1ns;
  import crd_pkg::*;
  logic awake;
  logic pd_idle;

  // ==========================================================
  // helper levels
  assign awake = SLEEP_STATE == SLEEP_ACTIVE || SLEEP_STATE == SLEEP_IDLE;
  assign pd_idle = SLEEP_STATE == SLEEP_POWER_DOWN && !NVM_BUSY;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  // ==========================================================
  // assertions
  a_wd_osc_req:
    assert property (PERIPH_REQ.watchdog_enable |=> OSC_ENABLE[1])
    else $error("watchdog request did not power source 1");
  a_rtc_route:
    assert property (PERIPH_REQ.rtc_enable && $stable(PERIPH_REQ.rtc_source)
      |=> OSC_ENABLE[$past(PERIPH_REQ.rtc_source)])
    else $error("rtc request not routed to its source");
  a_tcd_route:
    assert property (PERIPH_REQ.control_timer_enable &&
      $stable(PERIPH_REQ.control_timer_source)
      |=> OSC_ENABLE[$past(PERIPH_REQ.control_timer_source)])
    else $error("control timer request not routed");
  a_wd_gate_cause:
    assert property (CLOCK_GATES.watchdog_clock
      |-> $past(PERIPH_REQ.watchdog_enable))
    else $error("watchdog clock without request");
  a_rtc_gate_cause:
    assert property (CLOCK_GATES.rtc_clock |-> $past(PERIPH_REQ.rtc_enable))
    else $error("rtc clock without request");
  a_tcd_gate_cause:
    assert property (CLOCK_GATES.control_timer_clock
      |-> $past(PERIPH_REQ.control_timer_enable))
    else $error("control timer clock without request");
  a_bod_sampled_only:
    assert property (CLOCK_GATES.brownout_clock
      |-> $past(PERIPH_REQ.brownout_sampled) &&
      $past(PERIPH_REQ.brownout_enable))
    else $error("brownout clock outside sampled mode");
  a_cpu_with_per:
    assert property (CLOCK_GATES.cpu_clock == CLOCK_GATES.peripheral_clock)
    else $error("cpu and peripheral ticks differ");
  a_pin_is_tick:
    assert property (CLOCK_OUTPUT_PIN |-> CLOCK_GATES.peripheral_clock)
    else $error("clock output pin without peripheral tick");
  a_main_keeps_running:
    assert property (awake && CLOCK_GATES.main_clock
      |=> CLOCK_GATES.main_clock)
    else $error("main clock stopped while awake");
  a_pd_stops_main:
    assert property (pd_idle |=> !CLOCK_GATES.main_clock)
    else $error("main clock runs in idle power-down");
  a_pd_busy_runs:
    assert property (!pd_idle && SLEEP_STATE == SLEEP_POWER_DOWN &&
      CLOCK_GATES.main_clock |=> CLOCK_GATES.main_clock)
    else $error("main clock stopped with memory busy");
  a_read_quiet:
    assert property (REG_RDATA != 8'h00 |-> $past(REG_READ))
    else $error("read data outside its cycle");

  // ==========================================================
  // coverage of the main scenarios
  c_wd: cover property (CLOCK_GATES.watchdog_clock);
  c_pin: cover property (CLOCK_OUTPUT_PIN);
  c_sb: cover property (SLEEP_STATE == SLEEP_STANDBY &&
    CLOCK_GATES.main_clock);
endmodule // crd_chk

bind crd_top crd_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) i_crd_chk (
  .CLK(CLK), .RST_B(RST_B), .REG_READ(REG_READ), .REG_RDATA(REG_RDATA),
  .SLEEP_STATE(SLEEP_STATE), .PERIPH_REQ(PERIPH_REQ), .NVM_BUSY(NVM_BUSY),
  .OSC_ENABLE(OSC_ENABLE), .CLOCK_GATES(CLOCK_GATES),
  .CLOCK_OUTPUT_PIN(CLOCK_OUTPUT_PIN));

`default_nettype wire

// ===== verification/tb_crd.sv
// testbench for the clock request block with a peripheral model.
// assumes a short start-up parameter; CE is held high except for one register write in the switch scenario.
`default_nettype none

module tb_crd;
  timeunit 1ns;
  timeprecision 1ns;
  import crd_pkg::*;
  localparam int SU = 8;
  localparam int LIMIT = 20000;
  localparam int B_MAIN = 6;
  localparam int B_PER = 4;
  localparam int B_RTC = 3;
  localparam int B_WD = 2;
  localparam int B_BOD = 1;
  localparam int B_TCD = 0;
  localparam int B_OSC = 8;
  logic CLK, RST_B, CE, REG_WRITE, REG_READ, NVM_BUSY, CLOCK_OUTPUT_PIN;
  logic [ADDR_W-1:0] REG_ADDR;
  logic [DATA_W-1:0] REG_WDATA, REG_RDATA;
  logic [NUM_SRC-1:0] OSC_ENABLE;
  crd_sleep_type SLEEP_STATE;
  crd_periph_req_type want, PERIPH_REQ;
  crd_gates_type CLOCK_GATES;
  logic [11:0] obs;
  int miscompares, n_tests, cyc;

  // one view of the oscillator, pin and gate output bits for the wait helpers
  assign obs = {OSC_ENABLE, CLOCK_OUTPUT_PIN, CLOCK_GATES};

  crd_top #(.STARTUP_CYCLES(SU)) i_crd_top (.CLK(CLK), .RST_B(RST_B),
    .CE(CE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WRITE(REG_WRITE), .REG_READ(REG_READ), .REG_RDATA(REG_RDATA),
    .SLEEP_STATE(SLEEP_STATE), .PERIPH_REQ(PERIPH_REQ), .NVM_BUSY(NVM_BUSY),
    .OSC_ENABLE(OSC_ENABLE), .CLOCK_GATES(CLOCK_GATES),
    .CLOCK_OUTPUT_PIN(CLOCK_OUTPUT_PIN));
  crd_periph_model i_crd_periph_model (.clk(CLK), .rst_b(RST_B),
    .want(want), .req(PERIPH_REQ));

  // ==========================================================
  // clock, timeout and closing report
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == LIMIT) begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic step(input int n = 1);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_WRITE <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WRITE <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input string what, input logic [3:0] a,
    input logic [7:0] e);
    @(posedge CLK);
    REG_READ <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_READ <= 1'b0;
    #1;
    chk(what, e, REG_RDATA);
  endtask
  task automatic wait_bit(input int b, input logic v, input int lim,
    output int n);
    n = 0;
    #1; // never look in the time step of a launching edge
    while (obs[b] !== v && n < lim) begin
      step();
      n++;
    end
  endtask
  task automatic wchk(input string what, input int b, logic v, int lim);
    int n;
    wait_bit(b, v, lim, n);
    chk(what, 8'(v), 8'(obs[b]));
  endtask
  task automatic hold(input string what, input int b, logic v, int n);
    repeat (n) begin
      step();
      chk(what, 8'(v), 8'(obs[b]));
    end
  endtask
  task automatic set_req(input crd_periph_req_type w);
    @(posedge CLK);
    want <= w;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk("osc in reset", 8'h00, 8'(OSC_ENABLE));
    wchk("main up", B_MAIN, 1'b1, SU + 4);
    rchk("ctrl a", OFS_MAIN_CTRL_A, 8'h00);
    rchk("ctrl b", OFS_MAIN_CTRL_B, 8'h07);
    rchk("stdby", OFS_RUN_STDBY, 8'h00);
    rchk("status", OFS_STATUS, 8'h21);
    rchk("unmapped", 4'hF, 8'h00);
  endtask
  task automatic t_prescale;
    int divs [12] = '{1, 2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48};
    int n;
    wr(OFS_MAIN_CTRL_A, 8'h80);
    for (int c = 0; c < 12; c++) begin
      wr(OFS_MAIN_CTRL_B, 8'(c));
      repeat (2) begin
        wait_bit(B_PER, 1'b1, 70, n);
        step();
      end
      n = 1;
      while (obs[B_PER] !== 1'b1 && n < 70) begin
        chk("pin idle", 8'h00, 8'(CLOCK_OUTPUT_PIN));
        step();
        n++;
      end
      chk("divisor", 8'(divs[c]), 8'(n));
      chk("cpu tick", 8'h01, 8'(CLOCK_GATES.cpu_clock));
      chk("pin tick", 8'h01, 8'(CLOCK_OUTPUT_PIN));
    end
    wr(OFS_MAIN_CTRL_B, 8'h0C);
    rchk("bad code", OFS_MAIN_CTRL_B, 8'h0B);
    wr(OFS_MAIN_CTRL_B, 8'h07);
  endtask
  // one peripheral asks, gets its clock, then lets go
  task automatic t_async(input string s, crd_periph_req_type w, int g, o);
    set_req(w);
    wchk(s, B_OSC + o, 1'b1, 5);
    wchk(s, g, 1'b1, SU + 5);
    set_req('0);
    wchk(s, g, 1'b0, 4);
    wchk(s, B_OSC + o, 1'b0, 4);
  endtask
  task automatic t_warm;
    int n;
    wr(OFS_RUN_STDBY, 8'h02);
    wchk("stdby osc", B_OSC + 1, 1'b1, 4);
    step(SU + 2);
    set_req('{watchdog_enable: 1'b1, default: '0});
    wait_bit(B_WD, 1'b1, SU + 5, n);
    chk("warm start", 8'd2, 8'(n));
    set_req('0);
    SLEEP_STATE <= SLEEP_POWER_DOWN;
    wchk("pd osc off", B_OSC + 1, 1'b0, 4);
    wr(OFS_RUN_STDBY, 8'h00);
    SLEEP_STATE <= SLEEP_ACTIVE;
    wchk("main back", B_MAIN, 1'b1, SU + 5);
  endtask
  task automatic t_sleep;
    @(posedge CLK);
    SLEEP_STATE <= SLEEP_IDLE;
    hold("idle main", B_MAIN, 1'b1, 8);
    @(posedge CLK);
    SLEEP_STATE <= SLEEP_STANDBY;
    wchk("stdby stop", B_MAIN, 1'b0, 4);
    set_req('{main_request: 1'b1, default: '0});
    wchk("stdby run", B_MAIN, 1'b1, SU + 5);
    set_req('0);
    NVM_BUSY <= 1'b1;
    SLEEP_STATE <= SLEEP_POWER_DOWN;
    hold("nvm busy", B_MAIN, 1'b1, 8);
    @(posedge CLK);
    NVM_BUSY <= 1'b0;
    wchk("pd stop", B_MAIN, 1'b0, 4);
    @(posedge CLK);
    SLEEP_STATE <= SLEEP_ACTIVE;
    wchk("active", B_MAIN, 1'b1, SU + 5);
  endtask
  task automatic t_switch;
    wr(OFS_MAIN_CTRL_A, 8'h01);
    wchk("new osc", B_OSC + 1, 1'b1, 4);
    step(SU + 4);
    rchk("switched", OFS_STATUS, 8'h22);
    wr(OFS_RUN_STDBY, 8'h02);
    SLEEP_STATE <= SLEEP_STANDBY;
    hold("stdby warm", B_MAIN, 1'b1, 8);
    wr(OFS_RUN_STDBY, 8'h00);
    SLEEP_STATE <= SLEEP_ACTIVE;
    // a write while CE is low must leave every register alone
    @(posedge CLK);
    CE <= 1'b0;
    wr(OFS_RUN_STDBY, 8'h0F);
    CE <= 1'b1;
    rchk("ce freeze", OFS_RUN_STDBY, 8'h00);
    wr(OFS_MAIN_CTRL_A, 8'h80);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    RST_B = 1'b0;
    CE = 1'b1;
    REG_WRITE = 1'b0;
    REG_READ = 1'b0;
    REG_ADDR = '0;
    REG_WDATA = '0;
    NVM_BUSY = 1'b0;
    SLEEP_STATE = SLEEP_ACTIVE;
    want = '0;
    repeat (20) @(posedge CLK);
    RST_B <= 1'b1;
    #1;
    t_reset();
    t_prescale();
    t_async("wd", '{watchdog_enable: 1'b1, default: '0}, B_WD, 1);
    t_async("bod", '{brownout_enable: 1'b1, brownout_sampled: 1'b1,
      default: '0}, B_BOD, 1);
    t_async("rtc", '{rtc_enable: 1'b1, rtc_source: SRC_CRYSTAL,
      default: '0}, B_RTC, 2);
    t_async("tcd", '{control_timer_enable: 1'b1,
      control_timer_source: SRC_EXTERNAL, default: '0}, B_TCD, 3);
    set_req('{brownout_enable: 1'b1, default: '0});
    hold("bod plain", B_OSC + 1, 1'b0, SU + 4);
    set_req('0);
    t_warm();
    t_sleep();
    t_switch();
    test_done();
  end
endmodule // tb_crd

`default_nettype wire
